// [dcb_pkg.sv]
// Shared constants and types for the DDR2 command and burst block
package dcb_pkg;
   localparam int DCB_BANKS = 8;
   localparam int DCB_BANK_W = 3;
   localparam int DCB_ADDR_W = 13;
   localparam int DCB_COL_W = 10;
   localparam int DCB_DQ_W = 16;
   localparam int DCB_MASK_W = 2;
   localparam int DCB_AP_BIT = 10;
   localparam int DCB_BL4 = 4;
   localparam int DCB_BL8 = 8;
   localparam int DCB_LAT_W = 4;
   localparam int DCB_CNT_W = 6;
   localparam int DCB_FIFO_DEPTH = 16;
   localparam int DCB_MEM_DEPTH = 64;
   localparam int DCB_MEM_AW = 6;
   localparam logic [DCB_LAT_W-1:0] DCB_CL_RESET = 4'h4;
   localparam logic [DCB_LAT_W-1:0] DCB_AL_RESET = 4'h0;
   localparam logic [DCB_LAT_W-1:0] DCB_ONE = 4'h1;
   localparam logic [DCB_CNT_W-1:0] DCB_CNT_ONE = 6'h01;
   localparam logic [DCB_CNT_W-1:0] DCB_CNT_ZERO = 6'h00;
   localparam logic [2:0] DCB_MR_MAIN = 3'h0;
   localparam logic [2:0] DCB_MR_EXT = 3'h1;
   localparam int DCB_MR_BL_LSB = 0;
   localparam int DCB_MR_CL_LSB = 4;
   localparam int DCB_EMR_AL_LSB = 3;
   localparam logic [2:0] DCB_MR_BL8_CODE = 3'h3;
   typedef enum logic [3:0] {
      DCB_CMD_DESEL, DCB_CMD_NOP, DCB_CMD_LOAD, DCB_CMD_REFRESH, DCB_CMD_SELF,
      DCB_CMD_PRE, DCB_CMD_ACT, DCB_CMD_WRITE, DCB_CMD_READ, DCB_CMD_PDOWN
   } dcb_cmd_type;
   typedef enum logic [1:0] {DCB_PWR_ACTIVE, DCB_PWR_SELF, DCB_PWR_DOWN} dcb_pwr_type;
endpackage

// [dcb_fifo_if.sv]
// Valid/ready link between the array front end and the read FIFO
`timescale 1ns/1ns
interface dcb_fifo_if #(parameter int WIDTH = 16);
   logic valid;
   logic ready;
   logic [WIDTH-1:0] data;
   modport source (output valid, output data, input ready);
   modport sink (input valid, input data, output ready);
endinterface

// [dcb_fifo.sv]
// Parameterised synchronous FIFO for read data
`timescale 1ns/1ns
module dcb_fifo
   import dcb_pkg::*;
#(
   parameter int WIDTH = DCB_DQ_W,
   parameter int DEPTH = DCB_FIFO_DEPTH
)
(
   input wire logic clk_sys,
   input wire logic reset,
   dcb_fifo_if.sink inPort,
   dcb_fifo_if.source outPort
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wrPtr;
      logic [AW-1:0] rdPtr;
      logic [AW:0] count;
   } dcb_fifo_state_type;
   dcb_fifo_state_type st_r, st_nxt;
   logic [WIDTH-1:0] mem [DEPTH];
   logic pushOk, popOk;

   assign inPort.ready = (st_r.count != (AW+1)'(DEPTH));
   assign outPort.valid = (st_r.count != '0);
   assign outPort.data = mem[st_r.rdPtr];
   assign pushOk = inPort.valid && inPort.ready;
   assign popOk = outPort.valid && outPort.ready;

   always_comb
   begin
      st_nxt = st_r;
      if (pushOk)
      begin
         st_nxt.wrPtr = st_r.wrPtr + AW'(1);
      end
      if (popOk)
      begin
         st_nxt.rdPtr = st_r.rdPtr + AW'(1);
      end
      st_nxt.count = st_r.count + (AW+1)'(pushOk) - (AW+1)'(popOk);
   end

   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // Storage carries no reset so it can map to RAM
   always_ff @(posedge clk_sys)
   begin
      if (pushOk)
      begin
         mem[st_r.wrPtr] <= inPort.data;
      end
   end
endmodule // dcb_fifo

// [dcb_ddr2_device.sv]
// Command decoder, bank state and burst engine of a DDR2 device model
// Notes on behaviour
// - Commands decode from select, row, column, write strobe and clock enable at rising clock.
// - Deselect accepts no command; running operations continue.
// - No-operation starts nothing and leaves running operations alone.
// - Activate opens the addressed row in the chosen bank until precharged.
// - Read/write encoding; address bit ten requests auto precharge at burst end.
// - First read word arrives additive plus column latency after the read; the model delivers it two clocks later, via FIFO and output register.
// - Strobe driven with read data, no preamble before and a low postamble after.
// - A write byte is stored only when its mask is sampled low.
// - Write words captured from first strobe edge after write, then successive edges.
// - Self-refresh enters on refresh with clock enable low; exits when it rises.
// - Power-down from deselect or no-operation; no refresh performed meanwhile.
// - Precharge with bit ten high closes all banks, otherwise only the chosen one.
`timescale 1ns/1ns
module dcb_ddr2_device
   import dcb_pkg::*;
#(
   parameter int BANKS = DCB_BANKS,
   parameter int FIFO_DEPTH = DCB_FIFO_DEPTH
)
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic clockEnable,
   input wire logic chipSelectN,
   input wire logic rowStrobeN,
   input wire logic columnStrobeN,
   input wire logic writeStrobeN,
   input wire logic [DCB_BANK_W-1:0] bankSelect,
   input wire logic [DCB_ADDR_W-1:0] address,
   input wire logic [DCB_DQ_W-1:0] dataIn,
   input wire logic [DCB_MASK_W-1:0] byteMask,
   input wire logic strobeIn,
   output logic [DCB_DQ_W-1:0] dataOut,
   output logic dataOe,
   output logic strobeOut,
   output logic strobeOutN,
   output logic strobeOe,
   output logic [BANKS-1:0] bankOpen,
   output logic selfRefreshActive,
   output logic powerDownActive,
   output logic odtAvailable,
   output logic readFifoFull
);
   typedef struct packed {
      logic ckePrev;
      dcb_pwr_type pwr;
      logic [BANKS-1:0] open;
      logic [BANKS-1:0][DCB_ADDR_W-1:0] row;
      logic [DCB_LAT_W-1:0] columnLatency;
      logic [DCB_LAT_W-1:0] additiveLatency;
      logic burst8;
      logic [DCB_CNT_W-1:0] rdWait;
      logic [DCB_CNT_W-1:0] rdLeft;
      logic [DCB_MEM_AW-1:0] rdAddr;
      logic [DCB_BANK_W-1:0] rdBank;
      logic rdAutoPre;
      logic wrArmed;
      logic [DCB_CNT_W-1:0] wrLeft;
      logic [DCB_MEM_AW-1:0] wrAddr;
      logic [DCB_BANK_W-1:0] wrBank;
      logic wrAutoPre;
      logic strobePrev;
      logic [DCB_DQ_W-1:0] dataOut;
      logic dataOe;
      logic strobeOut;
      logic strobeOutN;
      logic strobeOe;
      logic [2:0] strobeSync;
      logic selfRefreshActive;
      logic powerDownActive;
      logic odtAvailable;
      logic readFifoFull;
   } dcb_dev_state_type;

   dcb_dev_state_type st_r, st_nxt;
   logic [DCB_DQ_W-1:0] array [DCB_MEM_DEPTH];
   localparam int BYTE_W = DCB_DQ_W / DCB_MASK_W;
   logic strobeRise, wrEnable;
   dcb_cmd_type cmd;
   logic [DCB_CNT_W-1:0] burstLen;
   dcb_fifo_if #(.WIDTH(DCB_DQ_W)) fifoIn();
   dcb_fifo_if #(.WIDTH(DCB_DQ_W)) fifoOut();

   // Strobe pin crosses into the clock domain; a rise counts when stages two and three agree
   assign strobeRise = st_r.strobeSync[1] && st_r.strobeSync[2] && !st_r.strobePrev;

   // Decode uses current clock enable and the one sampled last edge
   always_comb
   begin
      cmd = DCB_CMD_DESEL;
      if (!st_r.ckePrev)
      begin
         cmd = DCB_CMD_DESEL;
      end
      else if (chipSelectN)
      begin
         cmd = clockEnable ? DCB_CMD_DESEL : DCB_CMD_PDOWN;
      end
      else if (!rowStrobeN && !columnStrobeN && !writeStrobeN)
      begin
         cmd = DCB_CMD_LOAD;
      end
      else if (!rowStrobeN && !columnStrobeN)
      begin
         cmd = clockEnable ? DCB_CMD_REFRESH : DCB_CMD_SELF;
      end
      else if (!rowStrobeN && writeStrobeN)
      begin
         cmd = DCB_CMD_ACT;
      end
      else if (!rowStrobeN)
      begin
         cmd = DCB_CMD_PRE;
      end
      else if (!columnStrobeN)
      begin
         cmd = writeStrobeN ? DCB_CMD_READ : DCB_CMD_WRITE;
      end
      else
      begin
         cmd = clockEnable ? DCB_CMD_NOP : DCB_CMD_PDOWN;
      end
   end

   assign burstLen = st_r.burst8 ? DCB_CNT_W'(DCB_BL8) : DCB_CNT_W'(DCB_BL4);
   assign wrEnable = st_r.wrArmed && strobeRise && st_r.wrLeft != DCB_CNT_ZERO
      && cmd != DCB_CMD_WRITE;

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.ckePrev = clockEnable;
      st_nxt.strobeSync = {st_r.strobeSync[1:0], strobeIn};
      st_nxt.strobePrev = st_r.strobeSync[2];
      fifoIn.valid = 1'b0;
      fifoIn.data = array[st_r.rdAddr];
      fifoOut.ready = 1'b0;
      // Exit from low-power states needs no command, only clock enable rising
      if (st_r.pwr != DCB_PWR_ACTIVE && clockEnable)
      begin
         st_nxt.pwr = DCB_PWR_ACTIVE;
      end
      if (st_r.pwr == DCB_PWR_ACTIVE)
      begin
         case (cmd)
            DCB_CMD_LOAD:
            begin
               if (bankSelect == DCB_MR_MAIN)
               begin
                  st_nxt.burst8 = address[DCB_MR_BL_LSB+:3] == DCB_MR_BL8_CODE;
                  st_nxt.columnLatency = DCB_LAT_W'(address[DCB_MR_CL_LSB+:3]);
               end
               else if (bankSelect == DCB_MR_EXT)
               begin
                  st_nxt.additiveLatency = DCB_LAT_W'(address[DCB_EMR_AL_LSB+:3]);
               end
            end
            DCB_CMD_ACT:
            begin
               st_nxt.open[bankSelect] = 1'b1;
               st_nxt.row[bankSelect] = address;
            end
            DCB_CMD_PRE:
            begin
               if (address[DCB_AP_BIT])
               begin
                  st_nxt.open = '0;
               end
               else
               begin
                  st_nxt.open[bankSelect] = 1'b0;
               end
            end
            DCB_CMD_READ:
            begin
               // Read latency counts the command edge as cycle zero
               st_nxt.rdWait = DCB_CNT_W'(st_r.columnLatency + st_r.additiveLatency);
               st_nxt.rdLeft = burstLen;
               st_nxt.rdAddr = DCB_MEM_AW'(address[DCB_COL_W-1:0]);
               st_nxt.rdBank = bankSelect;
               st_nxt.rdAutoPre = address[DCB_AP_BIT];
            end
            DCB_CMD_WRITE:
            begin
               // A new write replaces any running one, truncating it
               st_nxt.wrArmed = 1'b1;
               st_nxt.wrLeft = burstLen;
               st_nxt.wrAddr = DCB_MEM_AW'(address[DCB_COL_W-1:0]);
               st_nxt.wrBank = bankSelect;
               st_nxt.wrAutoPre = address[DCB_AP_BIT];
            end
            DCB_CMD_SELF:
            begin
               st_nxt.pwr = DCB_PWR_SELF;
            end
            DCB_CMD_PDOWN:
            begin
               st_nxt.pwr = DCB_PWR_DOWN;
            end
            default:
            begin
            end
         endcase
      end
      // Read engine: wait out latency then one word per edge into the FIFO
      if (st_r.rdWait != DCB_CNT_ZERO && cmd != DCB_CMD_READ)
      begin
         st_nxt.rdWait = st_r.rdWait - DCB_CNT_ONE;
      end
      else if (st_r.rdWait == DCB_CNT_ZERO && st_r.rdLeft != DCB_CNT_ZERO
         && cmd != DCB_CMD_READ)
      begin
         fifoIn.valid = 1'b1;
         if (fifoIn.ready)
         begin
            st_nxt.rdLeft = st_r.rdLeft - DCB_CNT_ONE;
            st_nxt.rdAddr = st_r.rdAddr + DCB_MEM_AW'(1);
            // An activate on the same edge wins over the closing
            if (st_r.rdLeft == DCB_CNT_ONE && st_r.rdAutoPre
               && !(cmd == DCB_CMD_ACT && bankSelect == st_r.rdBank))
            begin
               st_nxt.open[st_r.rdBank] = 1'b0;
            end
         end
      end
      // Output stage: strobe toggles with each word, no preamble, low in the postamble
      fifoOut.ready = 1'b1;
      st_nxt.dataOe = fifoOut.valid;
      st_nxt.strobeOe = fifoOut.valid || st_r.strobeOe && st_r.dataOe;
      if (fifoOut.valid)
      begin
         st_nxt.dataOut = fifoOut.data;
         st_nxt.strobeOut = !st_r.strobeOut;
         st_nxt.strobeOutN = st_r.strobeOut;
      end
      else
      begin
         st_nxt.strobeOut = 1'b0;
         st_nxt.strobeOutN = 1'b1;
      end
      // Write engine
      if (st_r.wrArmed && strobeRise && cmd != DCB_CMD_WRITE)
      begin
         st_nxt.wrLeft = st_r.wrLeft - DCB_CNT_ONE;
         st_nxt.wrAddr = st_r.wrAddr + DCB_MEM_AW'(1);
         if (st_r.wrLeft == DCB_CNT_ONE)
         begin
            st_nxt.wrArmed = 1'b0;
            if (st_r.wrAutoPre && !(cmd == DCB_CMD_ACT && bankSelect == st_r.wrBank))
            begin
               st_nxt.open[st_r.wrBank] = 1'b0;
            end
         end
      end
      st_nxt.selfRefreshActive = st_nxt.pwr == DCB_PWR_SELF;
      st_nxt.powerDownActive = st_nxt.pwr == DCB_PWR_DOWN;
      st_nxt.odtAvailable = st_nxt.pwr != DCB_PWR_SELF;
      st_nxt.readFifoFull = !fifoIn.ready;
   end

   // Each byte lane keeps its old contents while its mask is high
   always_ff @(posedge clk_sys)
   begin
      for (int b = 0; b < DCB_MASK_W; b++)
      begin
         if (wrEnable && !byteMask[b])
         begin
            array[st_r.wrAddr][b*BYTE_W +: BYTE_W] <= dataIn[b*BYTE_W +: BYTE_W];
         end
      end
   end

   dcb_fifo #(.WIDTH(DCB_DQ_W), .DEPTH(FIFO_DEPTH)) readFifo (
      .clk_sys(clk_sys),
      .reset(reset),
      .inPort(fifoIn),
      .outPort(fifoOut)
   );

   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         st_r <= '0;
         st_r.columnLatency <= DCB_CL_RESET;
         st_r.additiveLatency <= DCB_AL_RESET;
         st_r.strobeOutN <= 1'b1;
         st_r.odtAvailable <= 1'b1;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign selfRefreshActive = st_r.selfRefreshActive;
   assign powerDownActive = st_r.powerDownActive;
   assign odtAvailable = st_r.odtAvailable;
   assign readFifoFull = st_r.readFifoFull;
   assign dataOut = st_r.dataOut;
   assign dataOe = st_r.dataOe;
   assign strobeOut = st_r.strobeOut;
   assign strobeOutN = st_r.strobeOutN;
   assign strobeOe = st_r.strobeOe;
   assign bankOpen = st_r.open;

   chk_act_opens_bank: assert property (@(posedge clk_sys) disable iff (reset)
      st_r.pwr == DCB_PWR_ACTIVE && cmd == DCB_CMD_ACT |=> bankOpen[$past(bankSelect)])
      else $error("activate did not open bank");
   chk_pre_all_closes: assert property (@(posedge clk_sys) disable iff (reset)
      st_r.pwr == DCB_PWR_ACTIVE && cmd == DCB_CMD_PRE && address[DCB_AP_BIT]
      && st_r.rdLeft == '0 |=> bankOpen == '0)
      else $error("precharge all left a bank open");
   chk_deselect_no_act: assert property (@(posedge clk_sys) disable iff (reset)
      chipSelectN && st_r.rdLeft == '0 && !st_r.wrArmed |=> $stable(bankOpen))
      else $error("deselect changed bank state");
   chk_nop_no_act: assert property (@(posedge clk_sys) disable iff (reset)
      cmd == DCB_CMD_NOP && st_r.rdLeft == '0 && !st_r.wrArmed |=> $stable(bankOpen))
      else $error("nop changed bank state");
   chk_self_entry: assert property (@(posedge clk_sys) disable iff (reset)
      st_r.pwr == DCB_PWR_ACTIVE && cmd == DCB_CMD_SELF |=> ##1 !odtAvailable)
      else $error("self refresh not entered");
   chk_pdown_entry: assert property (@(posedge clk_sys) disable iff (reset)
      st_r.pwr == DCB_PWR_ACTIVE && cmd == DCB_CMD_PDOWN |=> ##1 powerDownActive)
      else $error("power down not entered");
   chk_read_latency: assert property (@(posedge clk_sys) disable iff (reset)
      st_r.pwr == DCB_PWR_ACTIVE && cmd == DCB_CMD_READ && st_r.rdLeft == '0
      |=> st_r.rdWait == DCB_CNT_W'($past(st_r.columnLatency + st_r.additiveLatency)))
      else $error("read latency loaded wrongly");
   chk_preamble_low: assert property (@(posedge clk_sys) disable iff (reset)
      !st_r.dataOe |-> !strobeOut && strobeOutN)
      else $error("strobe not low outside data");
   chk_mask_blocks: assert property (@(posedge clk_sys) disable iff (reset)
      wrEnable && byteMask[0] |=> array[$past(st_r.wrAddr)][BYTE_W-1:0]
      == $past(array[st_r.wrAddr][BYTE_W-1:0]))
      else $error("masked byte written");
   chk_byte_stored: assert property (@(posedge clk_sys) disable iff (reset)
      wrEnable && !byteMask[0] |=> array[$past(st_r.wrAddr)][BYTE_W-1:0]
      == $past(dataIn[BYTE_W-1:0]))
      else $error("unmasked byte not stored");
   chk_write_first_edge: assert property (@(posedge clk_sys) disable iff (reset)
      st_r.wrArmed && strobeRise && cmd != DCB_CMD_WRITE
      |=> st_r.wrLeft == $past(st_r.wrLeft) - DCB_CNT_ONE)
      else $error("write word not captured on strobe edge");
endmodule // dcb_ddr2_device

// [dcb_ctrl_model.sv]
// Controller-side model that drives commands, write data and the write strobe
`timescale 1ns/1ns
module dcb_ctrl_model
   import dcb_pkg::*;
(
   input wire logic clk_sys,
   output logic clockEnable,
   output logic chipSelectN,
   output logic rowStrobeN,
   output logic columnStrobeN,
   output logic writeStrobeN,
   output logic [DCB_BANK_W-1:0] bankSelect,
   output logic [DCB_ADDR_W-1:0] address,
   output logic [DCB_DQ_W-1:0] dataIn,
   output logic [DCB_MASK_W-1:0] byteMask,
   output logic strobeIn
);
   initial
   begin
      clockEnable = 1'b1;
      {chipSelectN, rowStrobeN, columnStrobeN, writeStrobeN} = 4'h7;
      bankSelect = 3'h0;
      address = 13'h0000;
      dataIn = 16'h0000;
      byteMask = 2'h0;
      strobeIn = 1'b0;
   end

   // One command for one edge, then back to no-operation
   task automatic send(input dcb_cmd_type cmd, input logic [2:0] bank, input logic [12:0] addr);
      logic [3:0] enc;
      case (cmd)
         DCB_CMD_LOAD: enc = 4'h0;
         DCB_CMD_REFRESH: enc = 4'h1;
         DCB_CMD_PRE: enc = 4'h2;
         DCB_CMD_ACT: enc = 4'h3;
         DCB_CMD_WRITE: enc = 4'h4;
         DCB_CMD_READ: enc = 4'h5;
         DCB_CMD_DESEL: enc = 4'hb;
         default: enc = 4'h7;
      endcase
      @(negedge clk_sys);
      {chipSelectN, rowStrobeN, columnStrobeN, writeStrobeN} = enc;
      bankSelect = bank;
      address = addr;
      @(negedge clk_sys);
      {chipSelectN, rowStrobeN, columnStrobeN, writeStrobeN} = 4'h7;
      // Unused address lines keep moving so stale values never look valid
      address = ~addr;
   endtask

   // Four words, each held well past the strobe rise that captures it
   task automatic write_burst(input logic [2:0] bank, input logic [9:0] col, input logic ap,
      input logic [63:0] words, input logic [7:0] masks);
      send(DCB_CMD_WRITE, bank, {2'h0, ap, col});
      for (int i = 0; i < 4; i++)
      begin
         dataIn = words[16*i +: 16];
         byteMask = masks[2*i +: 2];
         repeat (4) @(negedge clk_sys);
         strobeIn = 1'b1;
         repeat (4) @(negedge clk_sys);
         strobeIn = 1'b0;
      end
      dataIn = ~dataIn;
      byteMask = ~byteMask;
      repeat (8) @(negedge clk_sys);
   endtask

   task automatic power(input logic enter, input logic selfRef);
      @(negedge clk_sys);
      clockEnable = ~enter;
      {chipSelectN, rowStrobeN, columnStrobeN, writeStrobeN} = (enter && selfRef) ? 4'h1 : 4'h7;
      @(negedge clk_sys);
      {chipSelectN, rowStrobeN, columnStrobeN, writeStrobeN} = 4'h7;
      if (!enter && selfRef)
         repeat (200) @(negedge clk_sys);
   endtask
endmodule // dcb_ctrl_model

// [tb_ddr2_command_and_burst_protocol.sv]
// Self-checking bench for the DDR2 command and burst block
`timescale 1ns/1ns
`define CHK(got, exp) \
   begin \
      totalChecks++; \
      if ((got) !== (exp)) \
      begin \
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); \
         badCount++; \
      end \
   end

module tb_ddr2_command_and_burst_protocol
   import dcb_pkg::*;
;
   logic clk_sys;
   logic reset;
   logic clockEnable, chipSelectN, rowStrobeN, columnStrobeN, writeStrobeN, strobeIn;
   logic [DCB_BANK_W-1:0] bankSelect;
   logic [DCB_ADDR_W-1:0] address;
   logic [DCB_DQ_W-1:0] dataIn;
   logic [DCB_MASK_W-1:0] byteMask;
   logic [DCB_DQ_W-1:0] dataOut;
   logic dataOe, strobeOut, strobeOutN, strobeOe;
   logic [DCB_BANKS-1:0] bankOpen;
   logic selfRefreshActive, powerDownActive, odtAvailable, readFifoFull;
   int badCount;
   int totalChecks;
   int lat0, lat, n;
   logic [63:0] q;

   initial
   begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   dcb_ctrl_model i_ctrl (.clk_sys(clk_sys), .clockEnable(clockEnable),
      .chipSelectN(chipSelectN), .rowStrobeN(rowStrobeN), .columnStrobeN(columnStrobeN),
      .writeStrobeN(writeStrobeN), .bankSelect(bankSelect), .address(address),
      .dataIn(dataIn), .byteMask(byteMask), .strobeIn(strobeIn));

   dcb_ddr2_device i_dut (.clk_sys(clk_sys), .reset(reset), .clockEnable(clockEnable),
      .chipSelectN(chipSelectN), .rowStrobeN(rowStrobeN), .columnStrobeN(columnStrobeN),
      .writeStrobeN(writeStrobeN), .bankSelect(bankSelect), .address(address),
      .dataIn(dataIn), .byteMask(byteMask), .strobeIn(strobeIn), .dataOut(dataOut),
      .dataOe(dataOe), .strobeOut(strobeOut), .strobeOutN(strobeOutN), .strobeOe(strobeOe),
      .bankOpen(bankOpen), .selfRefreshActive(selfRefreshActive),
      .powerDownActive(powerDownActive), .odtAvailable(odtAvailable),
      .readFifoFull(readFifoFull));

   task automatic results;
      $display("checks=%0d errors=%0d", totalChecks, badCount);
      if (badCount == 0 && totalChecks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Latency counted from the return of the command task
   task automatic rd(input logic [2:0] bank, input logic ap, input logic desel);
      lat = 0;
      n = 0;
      q = '0;
      i_ctrl.send(DCB_CMD_READ, bank, {2'h0, ap, 10'h008});
      if (desel)
      begin
         i_ctrl.send(DCB_CMD_DESEL, 3'h7, 13'h0001);
         lat = 2;
      end
      while (dataOe !== 1'b1 && lat < 60)
      begin
         @(negedge clk_sys);
         lat++;
      end
      while (dataOe === 1'b1 && n < 16)
      begin
         if (n < 4)
            q[16*n +: 16] = dataOut;
         `CHK(strobeOutN, ~strobeOut)
         @(negedge clk_sys);
         n++;
      end
      `CHK({strobeOe, strobeOut, strobeOutN}, 3'b101)
      repeat (2) @(negedge clk_sys);
   endtask

   initial
   begin
      #400000;
      badCount++;
      results;
   end

   initial
   begin
      reset = 1'b1;
      badCount = 0;
      totalChecks = 0;
      repeat (5) @(negedge clk_sys);
      `CHK({dataOe, strobeOe, strobeOutN, odtAvailable, selfRefreshActive, powerDownActive,
         readFifoFull, bankOpen}, 15'h1800)
      reset = 1'b0;
      i_ctrl.send(DCB_CMD_ACT, 3'h2, 13'h0011);
      `CHK(bankOpen, 8'h04)
      i_ctrl.send(DCB_CMD_ACT, 3'h5, 13'h0022);
      `CHK(bankOpen, 8'h24)
      i_ctrl.write_burst(3'h2, 10'h008, 1'b0, 64'h4444_3333_2222_1111, 8'h00);
      i_ctrl.write_burst(3'h2, 10'h008, 1'b0, 64'hdddd_cccc_bbbb_aaaa, 8'h04);
      rd(3'h2, 1'b0, 1'b1);
      lat0 = lat;
      `CHK(q, 64'hdddd_cccc_bb22_aaaa)
      `CHK(n, 4)
      `CHK(bankOpen, 8'h24)
      rd(3'h5, 1'b1, 1'b0);
      `CHK(bankOpen, 8'h04)
      i_ctrl.write_burst(3'h2, 10'h010, 1'b1, 64'h0123_4567_89ab_cdef, 8'h00);
      `CHK(bankOpen, 8'h00)
      i_ctrl.send(DCB_CMD_ACT, 3'h2, 13'h0001);
      i_ctrl.send(DCB_CMD_ACT, 3'h1, 13'h0002);
      i_ctrl.send(DCB_CMD_PRE, 3'h2, 13'h0000);
      `CHK(bankOpen, 8'h02)
      i_ctrl.send(DCB_CMD_ACT, 3'h6, 13'h0003);
      `CHK(bankOpen, 8'h42)
      i_ctrl.send(DCB_CMD_PRE, 3'h3, 13'h0400);
      `CHK(bankOpen, 8'h00)
      i_ctrl.send(DCB_CMD_LOAD, 3'h0, 13'h0053);
      i_ctrl.send(DCB_CMD_ACT, 3'h2, 13'h0001);
      rd(3'h2, 1'b0, 1'b0);
      `CHK(lat, lat0 + 1)
      `CHK(n, 8)
      i_ctrl.send(DCB_CMD_PRE, 3'h0, 13'h0400);
      i_ctrl.send(DCB_CMD_LOAD, 3'h1, 13'h0010);
      i_ctrl.send(DCB_CMD_ACT, 3'h2, 13'h0001);
      rd(3'h2, 1'b0, 1'b0);
      `CHK(lat, lat0 + 3)
      i_ctrl.send(DCB_CMD_PRE, 3'h0, 13'h0400);
      i_ctrl.power(1'b1, 1'b1);
      `CHK({selfRefreshActive, odtAvailable}, 2'b10)
      i_ctrl.send(DCB_CMD_ACT, 3'h3, 13'h0001);
      `CHK(bankOpen, 8'h00)
      i_ctrl.power(1'b0, 1'b1);
      `CHK({selfRefreshActive, odtAvailable}, 2'b01)
      i_ctrl.power(1'b1, 1'b0);
      `CHK(powerDownActive, 1'b1)
      i_ctrl.send(DCB_CMD_ACT, 3'h4, 13'h0001);
      `CHK(bankOpen, 8'h00)
      i_ctrl.power(1'b0, 1'b0);
      `CHK(powerDownActive, 1'b0)
      results;
   end
endmodule // tb_ddr2_command_and_burst_protocol
